// ==== hw/fep_pkg.sv ====
// constants, types and timing for the host-side flash erase/program sequencer
// assumes a 20 MHz core clock and a 128K x 8 part on an asynchronous bus
//
// Contract
// [RULE1] read: address valid, chip select and output enable low, write high
// [RULE2] device latches the address on the later falling strobe
// [RULE3] device latches the data on the earlier rising strobe
// [RULE4] device ignores write strobe pulses shorter than 20 ns
// [RULE5] device writes or erases only under the proper strobe combination
// [RULE6] writes may be write-strobe or chip-select controlled, same timing
// [RULE7] array is 128 sectors of 1024 bytes; upper seven lines pick sector
// [RULE8] sector erase: program supply high, one write, sector on upper lines
// [RULE9] erase starts only for an all-ones byte; else it is a byte write
// [RULE10] device waits up to 250 us abort delay; another write cancels
// [RULE11] sector erase sets every bit of the sector to one
// [RULE12] chip erase sets every bit of the array to one
// [RULE13] byte write only clears bits; only erase sets them again
// [RULE14] program: supply high, write non-all-ones bytes in ascending order
// [RULE15] each write is latched and self-timed; host waits before next access
// [RULE16] host repeats the write pass 15 times, verifies, then fill-in passes
// [RULE17] one pass may cover any set of sectors or the whole device
// [RULE18] patching a sector: copy it to local memory, merge, rewrite
// [RULE19] ident bytes: high voltage on tenth line, lowest bit picks byte
// [RULE20] after an erase wait 500 ms plus recovery before verifying

package fep_pkg;

  localparam int CLK_NS = 50;
  localparam int SECT_W = 7;
  localparam int BYTE_W = 10;
  localparam int SECT_BYTES = 1024;
  localparam int CNT_W = 26;
  localparam int SYNC_STAGES = 2;

  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [BYTE_W-1:0] IDX_LAST = 10'h3FF;
  localparam logic [3:0] PASSES = 4'hF;
  localparam logic [2:0] FILL_MAX = 3'h4;
  localparam logic STROBE_IDLE = 1'b1;

  // ==========================================================
  // bus timing
  localparam int T_AS_NS = 50;
  localparam int T_WP_NS = 150;
  localparam int T_AH_NS = 100;
  localparam int T_ACC_NS = 300;
  localparam int T_DF_NS = 100;
  localparam int T_VPS_US = 2;
  localparam int T_WC_US = 150;
  localparam int T_VPH_US = 250;
  localparam int T_ABORT_US = 250;
  localparam int T_ERASE_MS = 500;
  localparam int T_ERASE_RECOVERY_MS = 500;

  localparam int AS_CYC = (T_AS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int AH_CYC = (T_AH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int DF_CYC = (T_DF_NS + CLK_NS - 1) / CLK_NS;
  localparam int VPS_CYC = (T_VPS_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int WC_CYC = (T_WC_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int VPH_DEF_CYC = (T_VPH_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_WAIT_NS = T_ABORT_US * 1000
    + (T_ERASE_MS + T_ERASE_RECOVERY_MS) * 1000000;
  localparam int ERASE_DEF_CYC = (ERASE_WAIT_NS + CLK_NS - 1) / CLK_NS;

  // a state loaded with N-1 lasts N cycles
  localparam logic [CNT_W-1:0] AS_LOAD = CNT_W'(AS_CYC - 1);
  localparam logic [CNT_W-1:0] WP_LOAD = CNT_W'(WP_CYC - 1);
  localparam logic [CNT_W-1:0] AH_LOAD = CNT_W'(AH_CYC - 1);
  localparam logic [CNT_W-1:0] ACC_LOAD = CNT_W'(ACC_CYC + SYNC_STAGES - 1);
  localparam logic [CNT_W-1:0] DF_LOAD = CNT_W'(DF_CYC - 1);
  localparam logic [CNT_W-1:0] VPS_LOAD = CNT_W'(VPS_CYC - 1);
  localparam logic [CNT_W-1:0] WC_LOAD = CNT_W'(WC_CYC - 1);
  localparam logic [CNT_W-1:0] WC_MIN = CNT_W'(WC_CYC);

  typedef enum logic [2:0] {
    OP_READ, OP_ID, OP_WRITE, OP_SERASE, OP_CERASE, OP_LOAD, OP_PROG
  } fep_op_e;

  typedef enum logic [3:0] {
    S_IDLE, S_VPP_UP, S_WR_SET, S_WR_PULSE, S_WR_HOLD, S_WR_WAIT,
    S_RD_ACC, S_RD_GAP, S_BUF_RD, S_BUF_CHK, S_VPP_DOWN, S_DONE
  } fep_st_e;

endpackage

// ==== hw/fep_buf.sv ====
// sector image buffer, one byte per entry, registered read data
// assumes both ports are used on the core clock only
`timescale 1ns/1ps

module fep_buf
  import fep_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic wr_i,
  input wire logic [BYTE_W-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [BYTE_W-1:0] raddr_i,
  output logic [7:0] rdata_o
);

  logic [7:0] mem [SECT_BYTES];
  logic [7:0] rdata_ff;

  always_ff @(posedge core_clk_i) begin
    if (en_i && wr_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rdata_ff <= 8'h00;
    end else if (en_i) begin
      rdata_ff <= mem[raddr_i];
    end
  end

  assign rdata_o = rdata_ff;

endmodule

// ==== hw/fep_ctrl.sv ====
// host controller that reads, writes, erases and programs the flash part
// assumes data lines are merged from data_lines_o/_oe_o by the board model
`timescale 1ns/1ps

module fep_ctrl
  import fep_pkg::*;
#(
  parameter int ERASE_WAIT_CYC = ERASE_DEF_CYC,
  parameter int VPP_HOLD_CYC = VPH_DEF_CYC
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire fep_op_e cmd_op_i,
  input wire logic [SECT_W+BYTE_W-1:0] cmd_addr_i,
  input wire logic [7:0] cmd_data_i,
  output logic done_o,
  output logic [7:0] rd_data_o,
  output logic err_o,
  input wire logic buf_wr_i,
  input wire logic [BYTE_W-1:0] buf_addr_i,
  input wire logic [7:0] buf_data_i,
  output logic [7:0] buf_rdata_o,
  output logic [SECT_W-1:0] sector_select_address_o,
  output logic [BYTE_W-1:0] byte_in_sector_address_o,
  output logic [7:0] data_lines_o,
  output logic data_lines_oe_o,
  input wire logic [7:0] data_lines_i,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic vpp_hv_o,
  output logic a9_hv_o
);

  localparam logic [CNT_W-1:0] ER_LOAD = CNT_W'(ERASE_WAIT_CYC - 1);
  localparam logic [CNT_W-1:0] VPH_LOAD = CNT_W'(VPP_HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] ER_MIN = CNT_W'(ERASE_WAIT_CYC);

  // ==========================================================
  // data line synchroniser
  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
    end else if (en_i) begin
      sync1_ff <= data_lines_i;
      sync2_ff <= sync1_ff;
    end
  end

  // ==========================================================
  // sequencer
  fep_st_e st_ff, nxt_st;
  fep_op_e op_ff, nxt_op;
  logic [SECT_W-1:0] sect_ff, nxt_sect;
  logic [BYTE_W-1:0] byte_ff, nxt_byte;
  logic [BYTE_W-1:0] idx_ff, nxt_idx;
  logic [7:0] dout_ff, nxt_dout;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [3:0] pass_ff, nxt_pass;
  logic [2:0] fill_ff, nxt_fill;
  logic doe_ff, nxt_doe;
  logic ce_n_ff, nxt_ce_n;
  logic oe_n_ff, nxt_oe_n;
  logic we_n_ff, nxt_we_n;
  logic vpp_ff, nxt_vpp;
  logic a9_ff, nxt_a9;
  logic csel_ff, nxt_csel;
  logic erased_ff, nxt_erased;
  logic hit_ff, nxt_hit;
  logic mism_ff, nxt_mism;
  logic err_ff, nxt_err;
  logic adv;
  logic mem_we;
  logic cnt_zero;
  logic erase_wr;
  logic [7:0] buf_q;

  assign cnt_zero = (cnt_ff == '0);
  // an all-ones write that the part takes as an erase
  assign erase_wr = (op_ff == OP_SERASE) || (op_ff == OP_CERASE && csel_ff)
    || (op_ff == OP_PROG && !erased_ff);

  always_comb begin
    nxt_st = st_ff;
    nxt_op = op_ff;
    nxt_sect = sect_ff;
    nxt_byte = byte_ff;
    nxt_idx = idx_ff;
    nxt_dout = dout_ff;
    nxt_rdata = rdata_ff;
    nxt_cnt = cnt_zero ? cnt_ff : cnt_ff - 26'h0000001;
    nxt_pass = pass_ff;
    nxt_fill = fill_ff;
    nxt_doe = doe_ff;
    nxt_ce_n = ce_n_ff;
    nxt_oe_n = oe_n_ff;
    nxt_we_n = we_n_ff;
    nxt_vpp = vpp_ff;
    nxt_a9 = a9_ff;
    nxt_csel = csel_ff;
    nxt_erased = erased_ff;
    nxt_hit = hit_ff;
    nxt_mism = mism_ff;
    nxt_err = err_ff;
    adv = 1'b0;
    mem_we = 1'b0;
    unique case (st_ff)
      S_IDLE: if (cmd_valid_i) begin
        nxt_op = cmd_op_i;
        nxt_sect = cmd_addr_i[SECT_W+BYTE_W-1:BYTE_W]; // RULE7
        nxt_byte = cmd_addr_i[BYTE_W-1:0];
        nxt_dout = cmd_data_i;
        nxt_idx = '0;
        nxt_pass = '0;
        nxt_fill = '0;
        nxt_csel = 1'b0;
        nxt_erased = 1'b0;
        nxt_mism = 1'b0;
        nxt_err = 1'b0;
        unique case (cmd_op_i)
          OP_READ, OP_LOAD: begin
            nxt_ce_n = 1'b0; // RULE1
            nxt_oe_n = 1'b0;
            nxt_cnt = ACC_LOAD;
            nxt_st = S_RD_ACC;
          end
          OP_ID: begin
            nxt_sect = '0; // RULE19
            nxt_byte = {9'h000, cmd_addr_i[0]};
            nxt_a9 = 1'b1;
            nxt_ce_n = 1'b0;
            nxt_oe_n = 1'b0;
            nxt_cnt = ACC_LOAD;
            nxt_st = S_RD_ACC;
          end
          OP_CERASE: begin
            // select step with the supply at logic level
            nxt_dout = ERASED_BYTE;
            nxt_ce_n = 1'b0;
            nxt_doe = 1'b1;
            nxt_cnt = AS_LOAD;
            nxt_st = S_WR_SET;
          end
          OP_WRITE, OP_SERASE, OP_PROG: begin
            if (cmd_op_i != OP_WRITE) begin
              nxt_dout = ERASED_BYTE; // RULE9
            end
            nxt_vpp = 1'b1; // RULE8
            nxt_cnt = VPS_LOAD;
            nxt_st = S_VPP_UP;
          end
          default: nxt_st = S_DONE;
        endcase
      end
      S_VPP_UP: if (cnt_zero) begin
        nxt_ce_n = 1'b0;
        nxt_doe = 1'b1;
        nxt_cnt = AS_LOAD;
        nxt_st = S_WR_SET;
      end
      S_WR_SET: if (cnt_zero) begin
        nxt_we_n = 1'b0; // RULE6
        nxt_cnt = WP_LOAD;
        nxt_st = S_WR_PULSE;
      end
      S_WR_PULSE: if (cnt_zero) begin
        // address and data stay put across both strobe edges
        nxt_we_n = 1'b1; // RULE3
        nxt_cnt = AH_LOAD;
        nxt_st = S_WR_HOLD;
      end
      S_WR_HOLD: if (cnt_zero) begin
        nxt_ce_n = 1'b1;
        nxt_doe = 1'b0;
        // erase waits out the abort delay, erase and recovery
        nxt_cnt = erase_wr ? ER_LOAD : WC_LOAD; // RULE10 RULE20
        nxt_st = S_WR_WAIT;
      end
      S_WR_WAIT: if (cnt_zero) begin // RULE15
        unique case (op_ff)
          OP_CERASE: begin
            if (!csel_ff) begin
              nxt_csel = 1'b1;
              nxt_vpp = 1'b1;
              nxt_cnt = VPS_LOAD;
              nxt_st = S_VPP_UP;
            end else begin
              nxt_cnt = VPH_LOAD;
              nxt_st = S_VPP_DOWN;
            end
          end
          OP_PROG: begin
            if (!erased_ff) begin
              // sector is all ones before any byte is written
              nxt_erased = 1'b1; // RULE13
              nxt_st = S_BUF_RD;
            end else begin
              adv = 1'b1;
            end
          end
          default: begin
            nxt_cnt = VPH_LOAD;
            nxt_st = S_VPP_DOWN;
          end
        endcase
      end
      S_RD_ACC: if (cnt_zero) begin
        nxt_ce_n = 1'b1;
        nxt_oe_n = 1'b1;
        nxt_cnt = DF_LOAD;
        nxt_st = S_RD_GAP;
        nxt_rdata = sync2_ff;
        mem_we = (op_ff == OP_LOAD); // RULE18
        nxt_hit = (op_ff == OP_PROG) && (sync2_ff != buf_q); // RULE16
        nxt_mism = mism_ff || nxt_hit;
      end
      S_RD_GAP: if (cnt_zero) begin
        unique case (op_ff)
          OP_LOAD: adv = 1'b1;
          OP_PROG: begin
            if (hit_ff) begin
              nxt_dout = buf_q;
              nxt_ce_n = 1'b0;
              nxt_doe = 1'b1;
              nxt_cnt = AS_LOAD;
              nxt_st = S_WR_SET;
            end else begin
              adv = 1'b1;
            end
          end
          default: begin
            nxt_a9 = 1'b0;
            nxt_st = S_DONE;
          end
        endcase
      end
      S_BUF_RD: nxt_st = S_BUF_CHK;
      S_BUF_CHK: begin
        if (buf_q != ERASED_BYTE) begin // RULE14
          nxt_dout = buf_q;
          nxt_ce_n = 1'b0;
          nxt_doe = 1'b1;
          nxt_cnt = AS_LOAD;
          nxt_st = S_WR_SET;
        end else begin
          adv = 1'b1;
        end
      end
      S_VPP_DOWN: if (cnt_zero) begin
        nxt_vpp = 1'b0;
        nxt_st = S_DONE;
      end
      S_DONE: nxt_st = S_IDLE;
    endcase
    if (adv) begin
      // bytes go out in ascending order within each pass
      nxt_idx = idx_ff + 10'h001; // RULE14
      if (idx_ff == IDX_LAST && op_ff == OP_LOAD) begin
        nxt_st = S_DONE;
      end else if (idx_ff == IDX_LAST && pass_ff < PASSES) begin
        nxt_pass = pass_ff + 4'h1; // RULE16 RULE17
        if (pass_ff == PASSES - 4'h1) begin
          nxt_mism = 1'b0;
          nxt_ce_n = 1'b0;
          nxt_oe_n = 1'b0;
          nxt_cnt = ACC_LOAD;
          nxt_st = S_RD_ACC;
        end else begin
          nxt_st = S_BUF_RD;
        end
      end else if (idx_ff == IDX_LAST) begin
        if (mism_ff && fill_ff != FILL_MAX) begin
          nxt_fill = fill_ff + 3'h1; // RULE16
          nxt_mism = 1'b0;
          nxt_ce_n = 1'b0;
          nxt_oe_n = 1'b0;
          nxt_cnt = ACC_LOAD;
          nxt_st = S_RD_ACC;
        end else begin
          nxt_err = mism_ff;
          nxt_cnt = VPH_LOAD;
          nxt_st = S_VPP_DOWN;
        end
      end else if (op_ff == OP_LOAD || pass_ff == PASSES) begin
        nxt_ce_n = 1'b0;
        nxt_oe_n = 1'b0;
        nxt_cnt = ACC_LOAD;
        nxt_st = S_RD_ACC;
      end else begin
        nxt_st = S_BUF_RD;
      end
    end
    if (nxt_op == OP_LOAD || nxt_op == OP_PROG) begin
      nxt_byte = nxt_idx; // RULE7
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      st_ff <= S_IDLE;
      op_ff <= OP_READ;
      sect_ff <= '0;
      byte_ff <= '0;
      idx_ff <= '0;
      dout_ff <= 8'h00;
      rdata_ff <= 8'h00;
      cnt_ff <= '0;
      pass_ff <= 4'h0;
      fill_ff <= 3'h0;
      doe_ff <= 1'b0;
      ce_n_ff <= STROBE_IDLE;
      oe_n_ff <= STROBE_IDLE;
      we_n_ff <= STROBE_IDLE;
      vpp_ff <= 1'b0;
      a9_ff <= 1'b0;
      csel_ff <= 1'b0;
      erased_ff <= 1'b0;
      hit_ff <= 1'b0;
      mism_ff <= 1'b0;
      err_ff <= 1'b0;
    end else if (en_i) begin
      st_ff <= nxt_st;
      op_ff <= nxt_op;
      sect_ff <= nxt_sect;
      byte_ff <= nxt_byte;
      idx_ff <= nxt_idx;
      dout_ff <= nxt_dout;
      rdata_ff <= nxt_rdata;
      cnt_ff <= nxt_cnt;
      pass_ff <= nxt_pass;
      fill_ff <= nxt_fill;
      doe_ff <= nxt_doe;
      ce_n_ff <= nxt_ce_n;
      oe_n_ff <= nxt_oe_n;
      we_n_ff <= nxt_we_n;
      vpp_ff <= nxt_vpp;
      a9_ff <= nxt_a9;
      csel_ff <= nxt_csel;
      erased_ff <= nxt_erased;
      hit_ff <= nxt_hit;
      mism_ff <= nxt_mism;
      err_ff <= nxt_err;
    end
  end

  fep_buf u_buf (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .en_i(en_i),
    .wr_i(mem_we || (st_ff == S_IDLE && buf_wr_i)),
    .waddr_i(st_ff == S_IDLE ? buf_addr_i : idx_ff),
    .wdata_i(st_ff == S_IDLE ? buf_data_i : sync2_ff),
    .raddr_i(st_ff == S_IDLE ? buf_addr_i : idx_ff),
    .rdata_o(buf_q)
  );

  assign cmd_ready_o = (st_ff == S_IDLE);
  assign done_o = (st_ff == S_DONE);
  assign rd_data_o = rdata_ff;
  assign err_o = err_ff;
  assign buf_rdata_o = buf_q;
  assign sector_select_address_o = sect_ff;
  assign byte_in_sector_address_o = byte_ff;
  assign data_lines_o = dout_ff;
  assign data_lines_oe_o = doe_ff;
  assign ce_n_o = ce_n_ff;
  assign oe_n_o = oe_n_ff;
  assign we_n_o = we_n_ff;
  assign vpp_hv_o = vpp_ff;
  assign a9_hv_o = a9_ff;

  // ==========================================================
  // checks
  logic [CNT_W-1:0] gap_ff;
  logic last_er_ff;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      gap_ff <= '1;
      last_er_ff <= 1'b0;
    end else if (en_i && !we_n_ff) begin
      gap_ff <= '0;
      last_er_ff <= erase_wr;
    end else if (en_i && gap_ff != '1) begin
      gap_ff <= gap_ff + 26'h0000001;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i || !en_i);

  sequence s_pulse;
    !we_n_o [*3];
  endsequence
  sequence s_hold;
    (we_n_o && $stable(data_lines_o) && $stable(byte_in_sector_address_o)
      && $stable(sector_select_address_o)) [*2];
  endsequence

  a_read_strobes: assert property ( // RULE1
    !oe_n_o |-> !ce_n_o && we_n_o && !data_lines_oe_o)
    else $error("read strobes out of order");
  a_write_strobes: assert property ( // RULE6
    !we_n_o |-> !ce_n_o && oe_n_o && data_lines_oe_o && !a9_hv_o)
    else $error("write strobes out of order");
  a_latch_stable: assert property ( // RULE15
    $fell(we_n_o) |-> s_pulse ##1 s_hold)
    else $error("write pulse or hold broken");
  a_erase_ones: assert property ( // RULE9
    !we_n_o && erase_wr |-> data_lines_o == ERASED_BYTE)
    else $error("erase request without all ones");
  a_vpp_setup: assert property ( // RULE8
    $fell(we_n_o) && vpp_hv_o |-> $past(vpp_hv_o, 40))
    else $error("program supply not settled");
  a_id_address: assert property ( // RULE19
    a9_hv_o |-> sector_select_address_o == '0
      && byte_in_sector_address_o[BYTE_W-1:1] == '0 && we_n_o && !vpp_hv_o)
    else $error("ident read with bad address");
  a_verify_after: assert property ( // RULE16
    st_ff == S_RD_ACC && op_ff == OP_PROG |-> pass_ff == PASSES)
    else $error("verify before all passes");
  a_prog_nonff: assert property ( // RULE14
    $fell(we_n_o) && op_ff == OP_PROG && erased_ff && pass_ff < PASSES
      |-> data_lines_o != ERASED_BYTE)
    else $error("all-ones byte written in a pass");
  a_write_gap: assert property ( // RULE15
    $fell(ce_n_o) |-> gap_ff >= (last_er_ff ? ER_MIN : WC_MIN))
    else $error("access before write finished");
  a_erase_gap: assert property ( // RULE20
    $fell(ce_n_o) && last_er_ff |-> gap_ff >= ER_MIN)
    else $error("access before erase recovery");

endmodule

// ==== testbench/fep_flash_model.sv ====
// behavioural flash part on the asynchronous bus of the host controller
// assumes one bus host, whose data drive is qualified by host_oe_i
`timescale 1ns/1ps

module fep_flash_model
  import fep_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] PART_ID = 8'hC3, // arbitrary value
  parameter int T_ACC_NS = 250,
  parameter int T_ABORT_NS = 1000
) (
  input wire logic [SECT_W-1:0] sect_i,
  input wire logic [BYTE_W-1:0] byte_i,
  input wire logic [7:0] host_data_i,
  input wire logic host_oe_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic vpp_hv_i,
  input wire logic a9_hv_i,
  output logic [7:0] bus_o,
  output int wr_cnt_o
);
  // ==========================================================
  // array and write latches
  logic [7:0] mem [0:131071];
  logic [16:0] lat_a;
  logic [6:0] pend_s;
  logic [7:0] last = 8'h00;
  logic armed = 1'b0;
  logic pend = 1'b0;
  logic csel = 1'b0;
  time t_fall;
  time t_pend;
  wire wr_act = !ce_n_i && !we_n_i && oe_n_i;
  wire rd_act = !ce_n_i && !oe_n_i && we_n_i;
  wire rd_ok;
  wire drive;
  wire [7:0] rd_val;

  initial begin
    wr_cnt_o = 0;
    foreach (mem[i]) mem[i] = ERASED_BYTE;
  end

  always @(posedge wr_act) begin
    lat_a = {sect_i, byte_i};
    t_fall = $time;
    armed = 1'b1;
  end

  // short strobes are noise; the mode follows supply level and data
  always @(negedge wr_act) begin
    if (armed && $time - t_fall >= 20) begin
      if (!vpp_hv_i) begin
        csel = 1'b1;
      end else if (host_data_i == ERASED_BYTE && csel) begin
        foreach (mem[i]) mem[i] = ERASED_BYTE;
        csel = 1'b0;
      end else if (host_data_i == ERASED_BYTE) begin
        pend = 1'b1;
        pend_s = lat_a[16:10];
        t_pend = $time;
      end else begin
        pend = 1'b0;
        csel = 1'b0;
        mem[lat_a] = mem[lat_a] & host_data_i;
        wr_cnt_o++;
      end
    end
    armed = 1'b0;
  end

  // ==========================================================
  // sector erase after the abort window
  always begin
    #100;
    if (pend && $time - t_pend >= T_ABORT_NS) begin
      for (int i = 0; i < SECT_BYTES; i++) begin
        mem[{pend_s, BYTE_W'(i)}] = ERASED_BYTE;
      end
      pend = 1'b0;
    end
  end

  // ==========================================================
  // read path; an undriven bus shows the inverse of its last value
  assign #(T_ACC_NS) rd_ok = rd_act;
  assign drive = rd_act && rd_ok;
  assign rd_val = !a9_hv_i ? mem[{sect_i, byte_i}]
    : (byte_i[0] ? PART_ID : MAKER_ID);
  assign bus_o = host_oe_i ? host_data_i : drive ? rd_val : ~last;

  always @(host_oe_i, drive, host_data_i, rd_val) begin
    if (host_oe_i || drive) last = host_oe_i ? host_data_i : rd_val;
  end
endmodule

// ==== testbench/flash_erase_program_interface_tb.sv ====
// self-checking bench for the flash erase/program host controller
// assumes the behavioural flash part of fep_flash_model
`timescale 1ns/1ps

module flash_erase_program_interface_tb
  import fep_pkg::*;
;
  localparam logic [7:0] MAKER_ID = 8'h5A; // arbitrary value
  localparam logic [7:0] PART_ID = 8'hC3; // arbitrary value

  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  fep_op_e cmd_op_i = OP_READ;
  logic [16:0] cmd_addr_i = 17'h00000;
  logic [7:0] cmd_data_i = 8'h00;
  logic buf_wr_i = 1'b0;
  logic [9:0] buf_addr_i = 10'h000;
  logic [7:0] buf_data_i = 8'h00;
  logic cmd_ready_o, done_o, err_o, oe_d, ce_n, oe_n, we_n, vpp, a9;
  logic [7:0] rd_data_o, buf_rdata_o, dout, bus;
  logic [6:0] sect;
  logic [9:0] byte_a;
  int wr_cnt, cyc, n_fail = 0, checks_done = 0;

  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end

  fep_ctrl #(.ERASE_WAIT_CYC(50), .VPP_HOLD_CYC(10)) DUT (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .en_i(1'b1),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i),
    .done_o(done_o), .rd_data_o(rd_data_o), .err_o(err_o),
    .buf_wr_i(buf_wr_i), .buf_addr_i(buf_addr_i), .buf_data_i(buf_data_i),
    .buf_rdata_o(buf_rdata_o), .sector_select_address_o(sect),
    .byte_in_sector_address_o(byte_a), .data_lines_o(dout),
    .data_lines_oe_o(oe_d), .data_lines_i(bus), .ce_n_o(ce_n),
    .oe_n_o(oe_n), .we_n_o(we_n), .vpp_hv_o(vpp), .a9_hv_o(a9)
  );

  fep_flash_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) u_flash (
    .sect_i(sect), .byte_i(byte_a), .host_data_i(dout), .host_oe_i(oe_d),
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .vpp_hv_i(vpp),
    .a9_hv_i(a9), .bus_o(bus), .wr_cnt_o(wr_cnt)
  );

  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // one command through the request port, waits a bounded time for done
  task automatic do_cmd(input fep_op_e op, input logic [16:0] a,
      input logic [7:0] d, input int lim);
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_op_i <= op;
    cmd_addr_i <= a;
    cmd_data_i <= d;
    @(negedge core_clk_i);
    while (cmd_ready_o !== 1'b1) @(negedge core_clk_i);
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b0;
    cyc = 0;
    do begin
      @(negedge core_clk_i);
      cyc++;
    end while (done_o !== 1'b1 && cyc < lim);
    chk("done", 1'b1, done_o);
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    @(negedge core_clk_i);
    chk("strobes", 3'h7, {ce_n, oe_n, we_n});
    chk("drives", 3'h0, {vpp, a9, oe_d});
    chk("status", 3'h4, {cmd_ready_o, done_o, err_o});
    chk("rd_data", 8'h00, rd_data_o);
    $display("reset test done");
  endtask

  task automatic t_read();
    u_flash.mem[{7'h12, 10'h155}] = 8'hA7;
    do_cmd(OP_READ, {7'h12, 10'h155}, 8'h00, 40);
    chk("read byte", 8'hA7, rd_data_o);
    chk("read cycles", 11, cyc);
    $display("read test done");
  endtask

  task automatic t_id();
    do_cmd(OP_ID, 17'h00000, 8'h00, 40);
    chk("maker byte", MAKER_ID, rd_data_o);
    do_cmd(OP_ID, 17'h00001, 8'h00, 40);
    chk("part byte", PART_ID, rd_data_o);
    $display("ident test done");
  endtask

  task automatic t_write();
    int w0;
    w0 = wr_cnt;
    u_flash.mem[17'h0A40C] = 8'hF0;
    u_flash.mem[17'h0A40D] = 8'h77;
    do_cmd(OP_WRITE, 17'h0A40C, 8'h3C, 10000);
    chk("written byte", 8'h30, u_flash.mem[17'h0A40C]);
    chk("neighbour", 8'h77, u_flash.mem[17'h0A40D]);
    chk("write count", 1, wr_cnt - w0);
    do_cmd(OP_READ, 17'h0A40C, 8'h00, 40);
    chk("read back", 8'h30, rd_data_o);
    $display("write test done");
  endtask

  task automatic t_serase();
    int bad;
    bad = 0;
    u_flash.mem[{7'h05, 10'h000}] = 8'h00;
    u_flash.mem[{7'h05, 10'h3FF}] = 8'h00;
    u_flash.mem[{7'h06, 10'h000}] = 8'h00;
    u_flash.mem[{7'h04, 10'h3FF}] = 8'h00;
    do_cmd(OP_SERASE, {7'h05, 10'h2A5}, 8'h00, 500);
    for (int i = 0; i < SECT_BYTES; i++) begin
      if (u_flash.mem[{7'h05, BYTE_W'(i)}] !== ERASED_BYTE) bad++;
    end
    chk("sector not erased", 0, bad);
    chk("next sector", 8'h00, u_flash.mem[{7'h06, 10'h000}]);
    chk("prev sector", 8'h00, u_flash.mem[{7'h04, 10'h3FF}]);
    $display("sector erase test done");
  endtask

  task automatic t_cerase();
    int bad;
    bad = 0;
    u_flash.mem[17'h00000] = 8'h00;
    u_flash.mem[17'h1FFFF] = 8'h12;
    do_cmd(OP_CERASE, 17'h00000, 8'h00, 5000);
    foreach (u_flash.mem[i]) begin
      if (u_flash.mem[i] !== ERASED_BYTE) bad++;
    end
    chk("chip not erased", 0, bad);
    $display("chip erase test done");
  endtask

  task automatic t_prog();
    int w0;
    u_flash.mem[{7'h03, 10'h008}] = 8'h00;
    for (int i = 0; i < SECT_BYTES; i++) begin
      @(posedge core_clk_i);
      buf_wr_i <= 1'b1;
      buf_addr_i <= BYTE_W'(i);
      buf_data_i <= (i == 7) ? 8'h5A : ERASED_BYTE;
    end
    @(posedge core_clk_i);
    buf_wr_i <= 1'b0;
    buf_addr_i <= 10'h007;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("buffer byte", 8'h5A, buf_rdata_o);
    w0 = wr_cnt;
    do_cmd(OP_PROG, {7'h03, 10'h000}, 8'h00, 100000);
    chk("programmed", 8'h5A, u_flash.mem[{7'h03, 10'h007}]);
    chk("erased first", 8'hFF, u_flash.mem[{7'h03, 10'h008}]);
    chk("pass writes", 15, wr_cnt - w0);
    chk("verify error", 1'b0, err_o);
    $display("program test done");
  endtask

  initial begin
    repeat (98000) @(posedge core_clk_i);
    n_fail++;
    $display("unexpected timeout: expected finish, seen hang");
    summarize();
  end

  initial begin
    repeat (4) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_read();
    t_id();
    t_write();
    t_serase();
    t_cerase();
    t_prog();
    summarize();
  end
endmodule
